// ### rtl/fgpm_pin_mux.sv
// Purpose: Control pin multiplexer for the external FIFO / programmable interface port.
// Assumes: Engine and FIFO logic sit outside; this block routes pins by configuration.
// Notes:   Link-side logic runs on the selected interface clock; config crosses in.
`timescale 1ns/100ps
`default_nettype none
`include "fgpm_defs.svh"
module fgpm_pin_mux (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         link_clk,
  input  wire logic [`FGPM_CFG_W-1:0]       interface_config_field,
  input  wire logic [`FGPM_RDY_W-1:0]       ready_pins,
  output logic      [`FGPM_RDY_W-1:0]       engine_ready,
  output fgpm_pkg::fgpm_slave_ctl_t         slave_ctl,
  input  wire logic [`FGPM_CTL_W-1:0]       engine_ctl,
  input  wire fgpm_pkg::fgpm_flags_t        fifo_flags,
  output logic      [`FGPM_CTL_W-1:0]       control_output,
  input  wire logic [7:0]                   a_side_fifo_data_bus,
  input  wire logic [7:0]                   b_side_fifo_data_bus,
  output logic      [7:0]                   a_side_data_q,
  output logic      [7:0]                   b_side_data_q,
  output logic                              a_side_wr_q,
  output logic                              b_side_wr_q,
  input  wire logic                         a_select,
  input  wire logic                         b_select,
  input  wire logic                         suspend_req,
  input  wire logic                         wakeup_n,
  output logic                              suspended,
  output logic                              osc_enable,
  output logic                              wake_irq
);
  // The interface clock itself is chosen at the clock tree; this block
  // runs on whatever link_clk the selector delivers.
  // External clock when select is high, internal 48-MHz when low

  // Only the decoded mode crosses into the link domain. Syncing the raw
  // two-bit field could briefly show the slave-FIFO code while both bits
  // flip from one engine code to another; one registered bit cannot.
  // The cost is one extra clk cycle of mode-change latency.
  wire  slave_mode = (interface_config_field == `FGPM_CFG_SLAVE_FIFO);
  logic slave_mode_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      slave_mode_q <= 1'b0;
    else
      slave_mode_q <= slave_mode;
  end

  logic slave_mode_link;
  fgpm_sync2 #(.W(1)) u_cfg_sync (
    .clk  (link_clk),
    .rst  (1'b0),
    .din  (slave_mode_q),
    .dout (slave_mode_link)
  );

  // Ready pins sampled on the interface clock, one synchroniser per pin.
  // Each pin is an independent level, so no bundle coherence is needed.
  logic [`FGPM_RDY_W-1:0] rdy_q;
  for (genvar gi = 0; gi < `FGPM_RDY_W; gi++)
  begin : g_rdy_sync
    fgpm_sync2 #(.W(1)) u_rdy_sync (
      .clk  (link_clk),
      .rst  (1'b0),
      .din  (ready_pins[gi]),
      .dout (rdy_q[gi])
    );
  end

  // Each function sees the pins only in its own mode
  assign engine_ready = slave_mode_link ? '0 : rdy_q;
  assign slave_ctl.a_out_fifo_output_enable = slave_mode_link & rdy_q[0];
  assign slave_ctl.b_out_fifo_output_enable = slave_mode_link & rdy_q[1];
  assign slave_ctl.slave_fifo_write_strobe  = slave_mode_link & rdy_q[2];
  assign slave_ctl.slave_fifo_read_strobe   = slave_mode_link & rdy_q[3];

  // Control outputs come from flops on the interface clock.
  wire [`FGPM_CTL_W-1:0] flag_vec = {fifo_flags.a_out_level_flag,
                                     fifo_flags.b_in_level_flag,
                                     fifo_flags.a_in_level_flag};
  wire [`FGPM_CTL_W-1:0] ctl_d = slave_mode_link ? flag_vec : engine_ctl;
  logic [`FGPM_CTL_W-1:0] ctl_q;
  always_ff @(posedge link_clk)
  begin
    ctl_q <= ctl_d;
  end
  assign control_output = ctl_q;

  // Data captured on the interface clock at a write strobe
  logic [7:0] a_dat_q;
  logic [7:0] b_dat_q;
  logic       a_wr_q;
  logic       b_wr_q;
  wire wr_now = slave_ctl.slave_fifo_write_strobe;
  always_ff @(posedge link_clk)
  begin
    a_wr_q <= wr_now & a_select;
    b_wr_q <= wr_now & b_select;
    if (wr_now & a_select)
      a_dat_q <= a_side_fifo_data_bus;
    if (wr_now & b_select)
      b_dat_q <= b_side_fifo_data_bus;
  end
  assign a_side_data_q = a_dat_q;
  assign b_side_data_q = b_dat_q;
  assign a_side_wr_q   = a_wr_q;
  assign b_side_wr_q   = b_wr_q;
  // Relies on a free-running link_clk: strobes are sampled, not latched

  // Wakeup pin is asynchronous to clk.
  logic wake_sync;
  fgpm_sync2 #(.W(1)) u_wake_sync (
    .clk  (clk),
    .rst  (sys_rst),
    .din  (~wakeup_n),
    .dout (wake_sync)
  );
  logic wake_prev_q;
  wire  wake_fall = wake_sync & ~wake_prev_q;

  fgpm_pkg::fgpm_susp_state_t st_q;
  fgpm_pkg::fgpm_susp_state_t st_d;
  logic irq_q;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      fgpm_pkg::FGPM_RUN:
        if (suspend_req & ~wake_sync)
          st_d = fgpm_pkg::FGPM_SUSP;
      fgpm_pkg::FGPM_SUSP:
        if (wake_fall)
          st_d = fgpm_pkg::FGPM_WAKE;
      fgpm_pkg::FGPM_WAKE:
        st_d = fgpm_pkg::FGPM_RUN;
      default:
        st_d = fgpm_pkg::FGPM_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q        <= fgpm_pkg::FGPM_RUN;
      wake_prev_q <= 1'b0;
      irq_q       <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      wake_prev_q <= wake_sync;
      irq_q       <= (st_q == fgpm_pkg::FGPM_SUSP) & wake_fall;
    end
  end

  assign suspended  = (st_q == fgpm_pkg::FGPM_SUSP);
  assign osc_enable = ~suspended;
  assign wake_irq   = irq_q;

  // Assertions.
  a_irq_cause: assert property (@(posedge clk) disable iff (sys_rst)
    wake_irq |-> $past(suspended) && $past(wake_fall))
    else $error("wake interrupt without suspended falling edge");
  a_irq_resume: assert property (@(posedge clk) disable iff (sys_rst)
    (suspended && wake_fall) |=> wake_irq && !suspended && osc_enable)
    else $error("wake edge did not resume");
  a_no_susp_low: assert property (@(posedge clk) disable iff (sys_rst)
    (!suspended && wake_sync) |=> !suspended)
    else $error("suspend entered while wakeup held low");
  a_susp_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == fgpm_pkg::FGPM_RUN && suspend_req && !wake_sync) |=> suspended)
    else $error("suspend request ignored");
  a_ctl_slave: assert property (@(posedge link_clk)
    $past(slave_mode_link) |-> control_output == $past(flag_vec))
    else $error("flags not on control outputs");
  a_ctl_engine: assert property (@(posedge link_clk)
    !$past(slave_mode_link) |-> control_output == $past(engine_ctl))
    else $error("engine control not on outputs");
  a_rdy_ignored: assert property (@(posedge link_clk)
    slave_mode_link |-> engine_ready == '0)
    else $error("engine sees pins in slave mode");
  a_strobe_route: assert property (@(posedge link_clk)
    !slave_mode_link |-> slave_ctl == '0)
    else $error("slave strobe outside slave mode");
  a_data_capture: assert property (@(posedge link_clk)
    (wr_now && a_select) |=> a_wr_q && a_side_data_q == $past(a_side_fifo_data_bus))
    else $error("A data not captured");
  a_oe_route: assert property (@(posedge link_clk)
    slave_mode_link |-> slave_ctl.a_out_fifo_output_enable == rdy_q[0])
    else $error("A output enable misrouted");

  // Remaining pin routes in slave-FIFO mode, and the engine view outside it.
  a_oe_b_route: assert property (@(posedge link_clk)
    slave_mode_link |->
      slave_ctl.b_out_fifo_output_enable == rdy_q[1])
    else $error("B output enable misrouted");

  a_wr_route: assert property (@(posedge link_clk)
    slave_mode_link |->
      slave_ctl.slave_fifo_write_strobe == rdy_q[2])
    else $error("write strobe misrouted");

  a_rd_route: assert property (@(posedge link_clk)
    slave_mode_link |->
      slave_ctl.slave_fifo_read_strobe == rdy_q[3])
    else $error("read strobe misrouted");

  a_rdy_engine: assert property (@(posedge link_clk)
    !slave_mode_link |->
      engine_ready == rdy_q)
    else $error("engine does not see ready pins");

  // Each control output bit carries its own flag in slave-FIFO mode.
  a_ctl_a_in: assert property (@(posedge link_clk)
    $past(slave_mode_link) |->
      control_output[0] == $past(fifo_flags.a_in_level_flag))
    else $error("A inbound flag not on control output 0");

  a_ctl_b_in: assert property (@(posedge link_clk)
    $past(slave_mode_link) |->
      control_output[1] == $past(fifo_flags.b_in_level_flag))
    else $error("B inbound flag not on control output 1");

  a_ctl_a_out: assert property (@(posedge link_clk)
    $past(slave_mode_link) |->
      control_output[2] == $past(fifo_flags.a_out_level_flag))
    else $error("A outbound flag not on control output 2");

  // Writes land only on the selected side and only with a strobe.
  a_data_b_capture: assert property (@(posedge link_clk)
    (wr_now && b_select) |=>
      b_wr_q && b_side_data_q == $past(b_side_fifo_data_bus))
    else $error("B data not captured");

  a_no_write_idle: assert property (@(posedge link_clk)
    !wr_now |=>
      !a_wr_q && !b_wr_q)
    else $error("write without strobe");

  a_b_unselected: assert property (@(posedge link_clk)
    (wr_now && !b_select) |=>
      !b_wr_q)
    else $error("B written while not selected");

  // Mode register, suspend and wakeup sequencing on the system clock.
  a_mode_sync: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |->
      slave_mode_q == $past(slave_mode))
    else $error("mode register does not follow configuration");

  a_irq_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    wake_irq |=>
      !wake_irq)
    else $error("wake interrupt longer than one cycle");

  a_no_wake_run: assert property (@(posedge clk) disable iff (sys_rst)
    !suspended |=>
      !wake_irq)
    else $error("wake interrupt while running");

  a_susp_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (suspended && !wake_fall) |=>
      suspended)
    else $error("suspend left without wakeup edge");

  a_run_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == fgpm_pkg::FGPM_RUN && !suspend_req) |=>
      !suspended)
    else $error("suspend entered without request");

  a_wake_return: assert property (@(posedge clk) disable iff (sys_rst)
    wake_irq |->
      !suspended && osc_enable)
    else $error("oscillator off during wake interrupt");

  c_wake: cover property (@(posedge clk) suspended ##1 wake_irq);
  c_read: cover property (@(posedge link_clk) slave_ctl.slave_fifo_read_strobe);
  c_refuse: cover property (@(posedge clk) suspend_req && wake_sync && !suspended);
  c_write: cover property (@(posedge link_clk) a_wr_q);
  c_mode: cover property (@(posedge link_clk) $rose(slave_mode_link));
endmodule
`default_nettype wire

// ### rtl/fgpm_defs.svh
// Purpose: Constants for the interface control pin multiplexer.
// Assumes: Included by its bare name from the package and the design files.
// Notes:   The configuration field encoding is not given, so the slave-FIFO code is a define.
`ifndef FGPM_DEFS_SVH
`define FGPM_DEFS_SVH
`define FGPM_CFG_W          2
`define FGPM_CFG_SLAVE_FIFO 2'h3
`define FGPM_CFG_RESET      2'h0
`define FGPM_RDY_W          4
`define FGPM_CTL_W          3
`endif

// ### rtl/fgpm_pkg.sv
// Purpose: Types shared by the pin multiplexer files.
// Assumes: fgpm_defs.svh holds the constants.
// Notes:   Nothing here is imported; users write fgpm_pkg::name.
`include "fgpm_defs.svh"
package fgpm_pkg;
  typedef enum logic [1:0] {
    FGPM_RUN  = 2'h0,
    FGPM_SUSP = 2'h1,
    FGPM_WAKE = 2'h2
  } fgpm_susp_state_t;

  typedef struct packed {
    logic a_out_fifo_output_enable;
    logic b_out_fifo_output_enable;
    logic slave_fifo_write_strobe;
    logic slave_fifo_read_strobe;
  } fgpm_slave_ctl_t;

  typedef struct packed {
    logic a_in_level_flag;
    logic b_in_level_flag;
    logic a_out_level_flag;
  } fgpm_flags_t;
endpackage

// ### rtl/fgpm_sync2.sv
// Purpose: Two-flop synchroniser for a bundle of levels.
// Assumes: The source is asynchronous to clk.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module fgpm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
`default_nettype wire

// ### verif/fgpm_fifo_master.sv
// Purpose: External FIFO master facing the control pin multiplexer.
// Assumes: The master owns the interface clock, ready pins, data buses and selects.
// Notes:   Released data buses show the inverse of their last value, never a stale copy.
`timescale 1ns/100ps
`default_nettype none
module fgpm_fifo_master (
  output logic       link_clk,
  output logic [3:0] ready_pins,
  output logic [7:0] a_bus,
  output logic [7:0] b_bus,
  output logic       a_select,
  output logic       b_select
);
  initial
  begin
    link_clk = 1'b0;
    ready_pins = 4'h0;
    a_bus = 8'h00;
    b_bus = 8'h00;
    a_select = 1'b0;
    b_select = 1'b0;
  end
  // The clock runs free from time zero with no gaps
  always #6 link_clk = ~link_clk;
  task automatic set_pins(input logic [3:0] p);
    @(posedge link_clk);
    ready_pins <= p;
  endtask
  // Strobe and data are held for hold edges so the synchroniser sees them
  task automatic write_byte(input logic side_b, input logic [7:0] d, input int hold);
    @(posedge link_clk);
    a_select <= ~side_b;
    b_select <= side_b;
    if (side_b)
      b_bus <= d;
    else
      a_bus <= d;
    ready_pins[2] <= 1'b1;
    repeat (hold) @(posedge link_clk);
    ready_pins[2] <= 1'b0;
    a_select <= 1'b0;
    b_select <= 1'b0;
    a_bus <= ~a_bus;
    b_bus <= ~b_bus;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_fifo_programmable_interface_engine_control_pin_mux.sv
// Purpose: Self-checking bench for the control pin multiplexer.
// Assumes: Link-side logic settles within a few interface clock edges.
// Notes:   Only the slave-FIFO code and one engine code are exercised.
`timescale 1ns/100ps
`default_nettype none
`include "fgpm_defs.svh"
module tb_fifo_programmable_interface_engine_control_pin_mux;
  logic                  clk, sys_rst, link_clk, a_select, b_select, suspend_req, wakeup_n;
  logic [1:0]            cfg;
  logic [3:0]            ready_pins, engine_ready;
  logic [2:0]            engine_ctl, control_output;
  logic [7:0]            a_bus, b_bus, a_side_data_q, b_side_data_q;
  logic                  a_side_wr_q, b_side_wr_q, suspended, osc_enable, wake_irq;
  fgpm_pkg::fgpm_slave_ctl_t slave_ctl;
  fgpm_pkg::fgpm_flags_t fifo_flags;
  int                    err_count, cmp_count;
  fgpm_fifo_master mst (.link_clk(link_clk), .ready_pins(ready_pins), .a_bus(a_bus),
    .b_bus(b_bus), .a_select(a_select), .b_select(b_select));
  fgpm_pin_mux dut_u (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .interface_config_field(cfg), .ready_pins(ready_pins), .engine_ready(engine_ready),
    .slave_ctl(slave_ctl), .engine_ctl(engine_ctl), .fifo_flags(fifo_flags),
    .control_output(control_output), .a_side_fifo_data_bus(a_bus),
    .b_side_fifo_data_bus(b_bus), .a_side_data_q(a_side_data_q),
    .b_side_data_q(b_side_data_q), .a_side_wr_q(a_side_wr_q), .b_side_wr_q(b_side_wr_q),
    .a_select(a_select), .b_select(b_select), .suspend_req(suspend_req),
    .wakeup_n(wakeup_n), .suspended(suspended), .osc_enable(osc_enable), .wake_irq(wake_irq));
  always #5 clk = ~clk;
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic t_pins(input logic [1:0] mode);
    logic       sl;
    logic [3:0] p;
    sl = (mode === `FGPM_CFG_SLAVE_FIFO);
    @(posedge clk);
    cfg <= mode;
    engine_ctl <= 3'h1;
    fifo_flags <= fgpm_pkg::fgpm_flags_t'(3'h3);
    for (int i = 0; i < 16; i++)
    begin
      p = 4'(i);
      mst.set_pins(p);
      repeat (4) @(posedge link_clk);
      #1;
      chk("engine_ready", sl ? 8'h00 : {4'h0, p}, 8'(engine_ready));
      chk("slave_ctl", sl ? {4'h0, p[0], p[1], p[2], p[3]} : 8'h00, 8'(slave_ctl));
    end
    // Flags are a_in=0, b_in=1, a_out=1, so the slave view differs from the engine view.
    chk("control_output", sl ? 8'h06 : 8'h01, 8'(control_output));
    mst.set_pins(4'h0);
  endtask
  task automatic t_write(input logic [1:0] mode, input logic side_b, input logic [7:0] d);
    logic       hit_a, hit_b, sl;
    logic [7:0] got;
    hit_a = 1'b0;
    hit_b = 1'b0;
    got = 8'h00;
    sl = (mode === `FGPM_CFG_SLAVE_FIFO);
    @(posedge clk);
    cfg <= mode;
    repeat (4) @(posedge link_clk);
    fork
      mst.write_byte(side_b, d, 5);
      for (int k = 0; k < 10; k++)
      begin
        @(posedge link_clk);
        #1;
        if (a_side_wr_q === 1'b1 && !hit_a) got = a_side_data_q;
        if (b_side_wr_q === 1'b1 && !hit_b) got = b_side_data_q;
        hit_a = hit_a | (a_side_wr_q === 1'b1);
        hit_b = hit_b | (b_side_wr_q === 1'b1);
      end
    join
    chk("a write seen", 8'(sl & ~side_b), 8'(hit_a));
    chk("b write seen", 8'(sl & side_b), 8'(hit_b));
    chk("written data", sl ? d : 8'h00, got);
  endtask
  task automatic t_suspend;
    int irqs;
    irqs = 0;
    @(posedge clk);
    suspend_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("suspended", 8'h01, 8'(suspended));
    chk("osc_enable", 8'h00, 8'(osc_enable));
    @(posedge clk);
    suspend_req <= 1'b0;
    @(posedge clk);
    wakeup_n <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      #1;
      if (wake_irq === 1'b1) irqs++;
    end
    chk("wake_irq cycles", 8'h01, 8'(irqs));
    chk("awake osc_enable", 8'h01, 8'(osc_enable));
    @(posedge clk);
    suspend_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("suspend refused", 8'h00, 8'(suspended));
    @(posedge clk);
    suspend_req <= 1'b0;
    wakeup_n <= 1'b1;
  endtask
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cfg = `FGPM_CFG_RESET;
    engine_ctl = 3'h0;
    fifo_flags = fgpm_pkg::fgpm_flags_t'(3'h0);
    suspend_req = 1'b0;
    wakeup_n = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    t_pins(2'h0);
    t_pins(`FGPM_CFG_SLAVE_FIFO);
    t_write(`FGPM_CFG_SLAVE_FIFO, 1'b0, 8'h5A);
    t_write(`FGPM_CFG_SLAVE_FIFO, 1'b1, 8'hC3);
    t_write(2'h0, 1'b0, 8'h96);
    t_suspend();
    conclude();
  end
  // About 2.7 us of traffic is expected; over eighteen times that means a hang.
  initial
  begin
    #50000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
